// >>> verilog/blc_pkg.sv
// Shared constants, carriers and helper functions for the black level loop.
// Assumes one clock at pixel rate; every clock edge is one pixel period.
package blc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int BLC_NUM_CH = 3;
    localparam int BLC_ADC_W = 16;
    localparam int BLC_LVL_LSB = 4;
    localparam int BLC_LVL_W = 12;
    localparam int BLC_TGT_W = 10;
    localparam int BLC_OFS_W = 10;
    localparam int BLC_SUM_W = 17;
    localparam int BLC_ERR_W = 14;
    localparam int BLC_CNT_W = 6;
    localparam int BLC_REG_W = 8;

    // Pixel clock rate, for reference only (no timed waits in this block)
    localparam int BLC_CLK_MHZ = 25;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] BLC_REG_CTRL = 8'h08;
    localparam logic [7:0] BLC_REG_POS = 8'h09;
    localparam logic [7:0] BLC_CTRL_RST = 8'h00;
    localparam logic [7:0] BLC_POS_RST = 8'h00;
    localparam logic [7:0] BLC_RD_NONE = 8'h00;

    // Reference edge select codes
    localparam logic [1:0] BLC_REF_TG = 2'h1;
    localparam logic [1:0] BLC_REF_CLAMP = 2'h2;

    // Line run code for unlimited operation
    localparam logic [1:0] BLC_LINES_INF = 2'h3;

    // Shift bases: averaging 4..32 samples, integration divide 8..64
    localparam logic [2:0] BLC_AVG_BASE = 3'h2;
    localparam logic [2:0] BLC_INT_BASE = 3'h3;

    // Offset DAC limits, two's complement
    localparam logic signed [BLC_OFS_W-1:0] BLC_OFS_MIN = 10'sh200;
    localparam logic signed [BLC_OFS_W-1:0] BLC_OFS_MAX = 10'sh1ff;
    localparam logic signed [BLC_OFS_W-1:0] BLC_OFS_RST = 10'sh000;

    // Line limits and counter ceiling
    localparam logic [BLC_CNT_W-1:0] BLC_LIM_15 = 6'h0f;
    localparam logic [BLC_CNT_W-1:0] BLC_LIM_31 = 6'h1f;
    localparam logic [BLC_CNT_W-1:0] BLC_LIM_63 = 6'h3f;
    localparam logic [BLC_CNT_W-1:0] BLC_CNT_ONE = 6'h01;
    localparam logic [BLC_CNT_W-1:0] BLC_CNT_ZERO = 6'h00;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [1:0] lines;
        logic [1:0] avg;
        logic [1:0] integ;
        logic [1:0] ref_sel;
    } blc_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [BLC_NUM_CH-1:0][BLC_ADC_W-1:0] code;
    } blc_adc_t;

    typedef struct packed {
        logic en;
        logic [1:0] chan;
        logic [BLC_OFS_W-1:0] value;
    } blc_ofs_wr_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [BLC_REG_W-1:0] wdata;
    } blc_reg_req_t;

    typedef struct packed {
        logic [BLC_NUM_CH-1:0][BLC_OFS_W-1:0] ofs;
    } blc_dac_t;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [2:0] blc_avg_shift(input logic [1:0] c);
        return BLC_AVG_BASE + {1'b0, c};
    endfunction

    function automatic logic [2:0] blc_int_shift(input logic [1:0] c);
        return BLC_INT_BASE + {1'b0, c};
    endfunction

    function automatic logic [BLC_CNT_W-1:0] blc_line_limit(input logic [1:0] c);
        case (c)
            2'h0: return BLC_LIM_15;
            2'h1: return BLC_LIM_31;
            default: return BLC_LIM_63;
        endcase
    endfunction

endpackage

// >>> verilog/blc_chan.sv
// One channel of the black level loop: sample sum, error and offset register.
// Assumes the controller frames the sums and pulses apply once per window.
`timescale 1ns/1ps
module blc_chan (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic accum_in,
    input wire logic [blc_pkg::BLC_ADC_W-1:0] code_in,
    input wire logic apply_in,
    input wire logic [2:0] avg_shift_in,
    input wire logic [2:0] int_shift_in,
    input wire logic [blc_pkg::BLC_TGT_W-1:0] target_in,
    input wire logic wr_in,
    input wire logic [blc_pkg::BLC_OFS_W-1:0] wr_value_in,
    output logic [blc_pkg::BLC_OFS_W-1:0] offset_out
);
    import blc_pkg::*;

    logic [BLC_SUM_W-1:0] sum_q;
    logic [BLC_SUM_W-1:0] sum_d;
    logic [BLC_SUM_W-1:0] sum_shr;
    logic [BLC_LVL_W-1:0] level;
    logic [BLC_LVL_W-1:0] avg;
    logic signed [BLC_ERR_W-1:0] err;
    logic signed [BLC_ERR_W-1:0] scaled;
    logic signed [BLC_ERR_W-1:0] ofs_sum;
    logic signed [BLC_OFS_W-1:0] ofs_q;
    logic signed [BLC_OFS_W-1:0] ofs_sat;

    ////////////////////////////////////////////////////////////////////////
    // Sample sum; the four low ADC bits are dropped before summing
    assign level = code_in[BLC_ADC_W-1:BLC_LVL_LSB];
    assign sum_d = (clear_in ? '0 : sum_q) + (accum_in ? {5'h00, level} : '0);

    // Power-of-two count, so the mean is a plain right shift
    assign sum_shr = sum_q >> avg_shift_in;
    assign avg = sum_shr[BLC_LVL_W-1:0];

    // Error is target minus mean, target zero-extended, unscaled, to the 12-bit level
    assign err = $signed({4'h0, target_in}) - $signed({2'h0, avg});
    // Only a fraction of the error is applied, which damps noise
    assign scaled = err >>> int_shift_in;
    assign ofs_sum = $signed({{(BLC_ERR_W-BLC_OFS_W){ofs_q[BLC_OFS_W-1]}}, ofs_q}) + scaled;

    // Clamp at the DAC ends instead of wrapping; no other limit
    assign ofs_sat = (ofs_sum < $signed({{(BLC_ERR_W-BLC_OFS_W){1'b1}}, BLC_OFS_MIN})) ?
                     BLC_OFS_MIN :
                     (ofs_sum > $signed({{(BLC_ERR_W-BLC_OFS_W){1'b0}}, BLC_OFS_MAX})) ?
                     BLC_OFS_MAX : ofs_sum[BLC_OFS_W-1:0];

    assign offset_out = ofs_q;

    ////////////////////////////////////////////////////////////////////////
    // Sum register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sum_q <= '0;
        end else begin
            sum_q <= sum_d;
        end
    end

    // Offset register; a software write wins over a loop update
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ofs_q <= BLC_OFS_RST;
        end else if (wr_in) begin
            ofs_q <= wr_value_in;
        end else if (apply_in) begin
            ofs_q <= ofs_sat;
        end
    end

endmodule

// >>> verilog/blc_loop.sv
// Black level correction loop: clamp window timing, line count, registers.
// Assumes one clock per pixel and inputs synchronous to clk_in.
// Assumes the window is kept off the input clamp pulse.
// Function
// - Loop can be switched off; offsets then change only by software writes.
// - While enabled, offsets are rewritten on each line the loop is active.
// - Each channel keeps its own offset value toward its own black level.
// - Two-bit field picks transfer-gate (01) or input-clamp (10) falling edge.
// - Clamp window starts n+1 pixel periods after the chosen reference edge.
// - Adjacent optical black samples are averaged, not a single pixel.
// - Control bits 5:4 select 4, 8, 16 or 32 samples per line.
// - Ten-bit target compared with ADC code bits 15:4.
// - Error is target minus the average after the samples are taken.
// - Error divided by 8, 16, 32 or 64 per bits 3:2 before adding.
// - Correction range is limited only by the offset DAC range.
// - Loop runs 15, 31, 63 lines after scan start, or always, per 7:6.
// - After the finite line count, offsets stop updating though enabled.
// - Unlimited setting updates every line while the loop is enabled.
`timescale 1ns/1ps
module blc_loop (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire blc_pkg::blc_reg_req_t reg_req_in,
    output logic [blc_pkg::BLC_REG_W-1:0] reg_rdata_out,
    input wire logic loop_enable_in,
    input wire logic [blc_pkg::BLC_TGT_W-1:0] target_black_level_in,
    input wire blc_pkg::blc_ofs_wr_t offset_wr_in,
    input wire logic start_of_scan_in,
    input wire logic transfer_gate_pulse_in,
    input wire logic input_clamp_pulse_in,
    input wire blc_pkg::blc_adc_t adc_in,
    output blc_pkg::blc_dac_t offset_dac_out,
    output logic black_clamp_window_out,
    output logic loop_update_out,
    output logic [blc_pkg::BLC_CNT_W-1:0] line_count_out
);
    import blc_pkg::*;

    // Idle, delay, averaging, one apply cycle
    typedef enum logic [1:0] {
        BLC_S_IDLE,
        BLC_S_DELAY,
        BLC_S_AVG,
        BLC_S_APPLY
    } blc_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    blc_ctrl_t ctrl_q;
    logic [BLC_REG_W-1:0] pos_q;

    logic [BLC_REG_W-1:0] rdata_q;
    logic [BLC_REG_W-1:0] rdata_d;

    blc_state_t state_q;
    blc_state_t state_d;

    logic [BLC_REG_W-1:0] delay_q;
    logic [BLC_REG_W-1:0] delay_d;

    logic [BLC_CNT_W-1:0] samp_q;
    logic [BLC_CNT_W-1:0] samp_d;

    logic [BLC_CNT_W-1:0] line_q;
    logic [BLC_CNT_W-1:0] line_d;

    logic tg_prev_q;
    logic clamp_prev_q;

    logic tg_fall;
    logic clamp_fall;
    logic ref_edge;

    logic [2:0] avg_shift;
    logic [2:0] int_shift;

    logic [BLC_CNT_W-1:0] samp_last_val;
    logic [BLC_CNT_W-1:0] line_limit;

    logic samp_take;
    logic samp_last;
    logic samp_clear;

    logic lines_left;
    logic update_ok;
    logic apply;

    logic wr_ctrl;
    logic wr_pos;

    ////////////////////////////////////////////////////////////////////////
    // Register decode; only the two mapped offsets store anything
    assign wr_ctrl = reg_req_in.wr && (reg_req_in.addr == BLC_REG_CTRL);

    assign wr_pos = reg_req_in.wr && (reg_req_in.addr == BLC_REG_POS);

    // Read mux; unmapped addresses read as zero
    assign rdata_d = (reg_req_in.addr == BLC_REG_CTRL) ? ctrl_q :
                     (reg_req_in.addr == BLC_REG_POS) ? pos_q :
                     BLC_RD_NONE;

    // Fields act at once; change them with the loop off
    // Control and position registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= BLC_CTRL_RST;
            pos_q <= BLC_POS_RST;
            rdata_q <= BLC_RD_NONE;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_req_in.wdata;
            end

            if (wr_pos) begin
                pos_q <= reg_req_in.wdata;
            end

            rdata_q <= rdata_d;
        end
    end

    // Read data is one cycle behind the address
    assign reg_rdata_out = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Reference edge detection
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tg_prev_q <= 1'b0;
            clamp_prev_q <= 1'b0;
        end else begin
            tg_prev_q <= transfer_gate_pulse_in;
            clamp_prev_q <= input_clamp_pulse_in;
        end
    end

    // Flops reset low, so no false fall after reset
    assign tg_fall = tg_prev_q && !transfer_gate_pulse_in;

    assign clamp_fall = clamp_prev_q && !input_clamp_pulse_in;

    // Codes 00 and 11 select no reference, so no window ever opens
    assign ref_edge = ((ctrl_q.ref_sel == BLC_REF_TG) && tg_fall) ||
                      ((ctrl_q.ref_sel == BLC_REF_CLAMP) && clamp_fall);

    ////////////////////////////////////////////////////////////////////////
    // Field decoding for the averaging, integration and line settings
    assign avg_shift = blc_avg_shift(ctrl_q.avg);

    assign int_shift = blc_int_shift(ctrl_q.integ);

    assign samp_last_val = (BLC_CNT_ONE << avg_shift) - BLC_CNT_ONE;

    assign line_limit = blc_line_limit(ctrl_q.lines);

    // The budget gates only the update, not the window
    // Finite settings stop once the line budget is used
    assign lines_left = (ctrl_q.lines == BLC_LINES_INF) || (line_q < line_limit);
    assign update_ok = loop_enable_in && lines_left;

    ////////////////////////////////////////////////////////////////////////
    // Window sequencing
    assign samp_take = (state_q == BLC_S_AVG) && adc_in.valid;

    assign samp_clear = (state_q == BLC_S_AVG) && (samp_q == BLC_CNT_ZERO);

    assign samp_last = samp_take && (samp_q == samp_last_val);

    // Offsets and line count move on the next edge
    assign apply = (state_q == BLC_S_APPLY) && update_ok;

    // Next state; an edge seen while busy is ignored until the line ends
    always_comb begin
        state_d = state_q;
        delay_d = delay_q;
        samp_d = samp_q;

        case (state_q)
            // Wait for the chosen reference fall
            BLC_S_IDLE: begin
                // Fresh count per window
                samp_d = BLC_CNT_ZERO;
                if (loop_enable_in && ref_edge) begin
                    if (pos_q == '0) begin
                        state_d = BLC_S_AVG;
                    end else begin
                        delay_d = pos_q - 8'h01;
                        state_d = BLC_S_DELAY;
                    end
                end
            end

            // n cycles between the edge cycle and the window, which opens n+1 after the edge
            BLC_S_DELAY: begin
                // Holds n-1 on entry
                if (delay_q == '0) begin
                    state_d = BLC_S_AVG;
                end else begin
                    delay_d = delay_q - 8'h01;
                end
            end

            // Only valid samples count
            BLC_S_AVG: begin
                // The last sample goes to the sum only
                if (samp_last) begin
                    state_d = BLC_S_APPLY;
                end else if (samp_take) begin
                    samp_d = samp_q + BLC_CNT_ONE;
                end
            end

            // One cycle, then the next line
            BLC_S_APPLY: begin
                state_d = BLC_S_IDLE;
            end

            // Unused code
            default: begin
                state_d = BLC_S_IDLE;
            end
        endcase

        // Disabling the loop abandons a window in progress
        if (!loop_enable_in) begin
            state_d = BLC_S_IDLE;
        end
    end

    // State registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= BLC_S_IDLE;
            delay_q <= '0;
            samp_q <= BLC_CNT_ZERO;
        end else begin
            state_q <= state_d;
            delay_q <= delay_d;
            samp_q <= samp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lines since start of scan; saturates so it never wraps back into range
    always_comb begin
        line_d = line_q;
        // Start of scan wins over an increment
        if (start_of_scan_in) begin
            line_d = BLC_CNT_ZERO;
        end else if ((state_q == BLC_S_APPLY) && (line_q != BLC_LIM_63)) begin
            line_d = line_q + BLC_CNT_ONE;
        end
    end

    // Line count register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            line_q <= BLC_CNT_ZERO;
        end else begin
            line_q <= line_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel datapath
    // A copy per channel trades area for timing
    for (genvar ch = 0; ch < BLC_NUM_CH; ch++) begin : g_chan
        logic wr_hit;

        // Channel code 3 matches none
        assign wr_hit = offset_wr_in.en && (offset_wr_in.chan == 2'(ch));

        // Each channel integrates its own error into its own offset
        blc_chan u_chan (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .clear_in(samp_clear),
            .accum_in(samp_take),
            .code_in(adc_in.code[ch]),
            .apply_in(apply),
            .avg_shift_in(avg_shift),
            .int_shift_in(int_shift),
            .target_in(target_black_level_in),
            .wr_in(wr_hit),
            .wr_value_in(offset_wr_in.value),
            .offset_out(offset_dac_out.ofs[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Status outputs decoded from flip-flops; the update pulse is also gated by loop_enable_in
    assign black_clamp_window_out = (state_q == BLC_S_AVG);

    assign loop_update_out = apply;

    // Count shows when the line budget is spent
    assign line_count_out = line_q;

endmodule

// >>> testbench/blc_loop_sva.sv
// Checker for the black level loop; sees only the ports of blc_loop.
// Assumes one pixel clock and mirrors the two control registers from writes.
`timescale 1ns/1ps
module blc_loop_sva (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire blc_pkg::blc_reg_req_t reg_req_in,
    input wire logic [blc_pkg::BLC_REG_W-1:0] reg_rdata_out,
    input wire logic loop_enable_in,
    input wire blc_pkg::blc_ofs_wr_t offset_wr_in,
    input wire logic start_of_scan_in,
    input wire logic transfer_gate_pulse_in,
    input wire logic input_clamp_pulse_in,
    input wire blc_pkg::blc_adc_t adc_in,
    input wire blc_pkg::blc_dac_t offset_dac_out,
    input wire logic black_clamp_window_out,
    input wire logic loop_update_out,
    input wire logic [blc_pkg::BLC_CNT_W-1:0] line_count_out
);
    import blc_pkg::*;
    logic [7:0] ctrl_q;
    logic [7:0] pos_q;
    logic tg_q;
    logic cl_q;
    logic [8:0] since_q;
    logic [6:0] vcnt_q;
    // Reference fall, sample count and line limit as the control register selects
    wire ref_fall = (ctrl_q[1:0] == 2'h1 && tg_q && !transfer_gate_pulse_in)
        || (ctrl_q[1:0] == 2'h2 && cl_q && !input_clamp_pulse_in);
    wire [6:0] n_samp = 7'h04 << ctrl_q[5:4];
    wire [5:0] lim = (ctrl_q[7:6] == 2'h0) ? 6'h0f : (ctrl_q[7:6] == 2'h1) ? 6'h1f : 6'h3f;
    wire wr_ok = offset_wr_in.en && offset_wr_in.chan != 2'h3;
    // Mirrors; the age counter saturates so a long idle never wraps into a match
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= 8'h00;
            pos_q <= 8'h00;
            tg_q <= 1'b0;
            cl_q <= 1'b0;
            since_q <= 9'h000;
            vcnt_q <= 7'h00;
        end else begin
            if (reg_req_in.wr && reg_req_in.addr == 8'h08) ctrl_q <= reg_req_in.wdata;
            if (reg_req_in.wr && reg_req_in.addr == 8'h09) pos_q <= reg_req_in.wdata;
            tg_q <= transfer_gate_pulse_in;
            cl_q <= input_clamp_pulse_in;
            since_q <= ref_fall ? 9'h001 : since_q + {8'h00, since_q != 9'h1ff};
            vcnt_q <= !black_clamp_window_out ? 7'h00 : vcnt_q + {6'h00, adc_in.valid};
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_reg_hold;
        reg_req_in.wr && reg_req_in.addr inside {8'h08, 8'h09}
            ##1 !reg_req_in.wr && $stable(reg_req_in.addr);
    endsequence
    sequence s_win_done;
        loop_enable_in && black_clamp_window_out ##1 loop_enable_in && !black_clamp_window_out;
    endsequence
    reg_readback_a:
        assert property (s_reg_hold |=> reg_rdata_out == $past(reg_req_in.wdata, 2))
        else $error("register read back differs from write");
    unmapped_read_a:
        assert property (!(reg_req_in.addr inside {8'h08, 8'h09}) |=> reg_rdata_out == 8'h00)
        else $error("unmapped address read not zero");
    offset_write_a:
        assert property (wr_ok |=> offset_dac_out.ofs[$past(offset_wr_in.chan)]
            == $past(offset_wr_in.value))
        else $error("offset write not taken");
    offset_hold_a:
        assert property (!loop_update_out && !wr_ok |=> $stable(offset_dac_out))
        else $error("offset changed without cause");
    window_start_a:
        assert property ($rose(black_clamp_window_out) |-> since_q == {1'b0, pos_q} + 9'h001)
        else $error("window start delay wrong");
    sample_count_a:
        assert property (s_win_done |-> vcnt_q == n_samp)
        else $error("window sample count wrong");
    update_gate_a:
        assert property (s_win_done |-> loop_update_out
            == (ctrl_q[7:6] == 2'h3 || line_count_out < lim))
        else $error("update pulse disagrees with line limit");
    update_origin_a:
        assert property (loop_update_out |-> $past(black_clamp_window_out)
            && !black_clamp_window_out)
        else $error("update pulse without window end");
    line_step_a:
        assert property (s_win_done ##0 !start_of_scan_in |=> line_count_out
            == ($past(line_count_out) == 6'h3f ? 6'h3f : $past(line_count_out) + 6'h01))
        else $error("line count step wrong");
    scan_clear_a:
        assert property (start_of_scan_in |=> line_count_out == 6'h00)
        else $error("line count not cleared");
endmodule
bind blc_loop blc_loop_sva i_sva (
    .clk_in, .rst_n_in, .reg_req_in, .reg_rdata_out, .loop_enable_in, .offset_wr_in,
    .start_of_scan_in, .transfer_gate_pulse_in, .input_clamp_pulse_in, .adc_in,
    .offset_dac_out, .black_clamp_window_out, .loop_update_out, .line_count_out
);

// >>> testbench/blc_sensor_model.sv
// ADC sample stream of the three channels feeding the loop.
// Assumes the bench sets the black level per channel; slow mode halves valid.
`timescale 1ns/1ps
module blc_sensor_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic slow_in,
    input wire logic [blc_pkg::BLC_NUM_CH-1:0][blc_pkg::BLC_ADC_W-1:0] base_in,
    output blc_pkg::blc_adc_t adc_out
);
    import blc_pkg::*;
    logic up_q;
    // Samples swing around the level so a one-pixel reading would be off
    always @(negedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            adc_out <= '0;
            up_q <= 1'b0;
        end else if (slow_in && adc_out.valid) begin
            adc_out.valid <= 1'b0;
            adc_out.code <= ~adc_out.code; // Gap cycles never repeat the last code
        end else begin
            adc_out.valid <= 1'b1;
            up_q <= ~up_q;
            for (int c = 0; c < BLC_NUM_CH; c++)
                adc_out.code[c] <= up_q ? base_in[c] + 16'h0040 : base_in[c] - 16'h0040;
        end
    end
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for blc_loop with the ADC stream model.
// Assumes inputs change on the falling clock edge only.
`timescale 1ns/1ps
module tb_top;
    import blc_pkg::*;
    logic clk_in, rst_n_in, en, sos, tg, cl, slow, u, win, upd;
    blc_reg_req_t req;
    blc_ofs_wr_t owr;
    blc_adc_t adc;
    blc_dac_t dac;
    logic [7:0] rdata;
    logic [9:0] tgt;
    logic [1:0] ig;
    logic [5:0] lines;
    logic [15:0] d;
    logic [2:0][15:0] base;
    logic [2:0][9:0] ev;
    logic [9:0] ini [3];
    logic [31:0] lim_exp [4];
    int miscompares, n_compared, cyc, k, c, j, nu;
    blc_loop i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .loop_enable_in(en), .target_black_level_in(tgt),
        .offset_wr_in(owr), .start_of_scan_in(sos), .transfer_gate_pulse_in(tg),
        .input_clamp_pulse_in(cl), .adc_in(adc), .offset_dac_out(dac),
        .black_clamp_window_out(win), .loop_update_out(upd), .line_count_out(lines));
    blc_sensor_model i_adc (.clk_in(clk_in), .rst_n_in(rst_n_in), .slow_in(slow),
        .base_in(base), .adc_out(adc));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("compares %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_in);
        req = '{wr: 1'b1, addr: a, wdata: v};
        @(negedge clk_in);
        req.wr = 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_in);
        req.addr = a;
        @(negedge clk_in);
        chk({24'h0, rdata}, {24'h0, e});
    endtask
    task automatic ofs_wr(input logic [1:0] ch, input logic [9:0] v);
        @(negedge clk_in);
        owr = '{en: 1'b1, chan: ch, value: v};
        @(negedge clk_in);
        owr.en = 1'b0;
    endtask
    // One line: reference pulse, then wait out the window; d counts to its start
    task automatic run_line(input logic clampsel, output logic up, output logic [15:0] dl);
        int i;
        dl = 16'h0000;
        @(negedge clk_in);
        if (clampsel) cl = 1'b1; // window lies after the clamp pulse
        else tg = 1'b1;
        @(negedge clk_in);
        tg = 1'b0;
        cl = 1'b0;
        for (i = 0; i < 300 && !win; i++) begin
            @(negedge clk_in);
            dl++;
        end
        for (i = 0; i < 300 && win; i++) @(negedge clk_in);
        up = upd;
        repeat (2) @(negedge clk_in);
    endtask
    function automatic logic [9:0] exp_ofs(input logic [9:0] o, input logic [15:0] b,
        input logic [9:0] t, input logic [1:0] g);
        logic signed [15:0] e;
        e = $signed({6'h00, t}) - $signed({4'h0, b[15:4]});
        e = e >>> (3 + g);
        e = $signed({{6{o[9]}}, o}) + e;
        if (e > 16'sd511) e = 16'sd511;
        if (e < -16'sd512) e = -16'sd512;
        return e[9:0];
    endfunction
    ////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // Hang guard: a stalled handshake ends the run as a failure
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        rst_n_in = 1'b0;
        {en, sos, tg, cl, slow} = 5'h00;
        req = '0;
        owr = '0;
        tgt = 10'h000;
        base = {16'h8045, 16'hffa0, 16'h0048};
        ini = '{10'h1f4, 10'h39c, 10'h000};
        lim_exp = '{32'h0f, 32'h1f, 32'h3f, 32'h40};
        repeat (12) @(posedge clk_in);
        @(negedge clk_in) rst_n_in = 1'b1;
        reg_rd(BLC_REG_CTRL, 8'h00);
        reg_rd(BLC_REG_POS, 8'h00);
        reg_wr(BLC_REG_POS, 8'h5a);
        reg_rd(BLC_REG_POS, 8'h5a);
        reg_wr(8'h0a, 8'hff);
        reg_rd(8'h0a, 8'h00);
        reg_rd(BLC_REG_CTRL, 8'h00);
        for (c = 0; c < 3; c++) ofs_wr(2'(c), ini[c]);
        ofs_wr(2'h3, 10'h155);
        chk({2'h0, dac}, {2'h0, ini[2], ini[1], ini[0]});
        // Loop off, then reference code 00: neither may touch the offsets
        reg_wr(BLC_REG_CTRL, 8'hc1);
        run_line(1'b0, u, d);
        chk({31'h0, u}, 32'h0);
        chk({2'h0, dac}, {2'h0, ini[2], ini[1], ini[0]});
        en = 1'b1;
        reg_wr(BLC_REG_CTRL, 8'hc0);
        run_line(1'b0, u, d);
        chk({31'h0, u}, 32'h0);
        // Every average and divide code, both references, both sample paces
        for (k = 0; k < 5; k++) begin
            tgt = (k == 4) ? 10'h000 : 10'h3ff;
            slow = k[0];
            ig = (k == 4) ? 2'h0 : 2'(3 - k);
            reg_wr(BLC_REG_POS, 8'(k * 5));
            reg_wr(BLC_REG_CTRL, {2'h3, 2'(k), ig, (k[0] ? 2'h2 : 2'h1)});
            for (c = 0; c < 3; c++) ofs_wr(2'(c), ini[c]);
            run_line(k[0], u, d);
            chk({16'h0, d}, 32'(k * 5 + 1));
            chk({31'h0, u}, 32'h1);
            for (c = 0; c < 3; c++) ev[c] = exp_ofs(ini[c], base[c], tgt, ig);
            chk({2'h0, dac}, {2'h0, ev});
        end
        // Line limits 15, 31, 63 and unlimited over 64 lines each
        slow = 1'b0;
        reg_wr(BLC_REG_POS, 8'h00);
        for (k = 0; k < 4; k++) begin
            reg_wr(BLC_REG_CTRL, {2'(k), 2'h0, 2'h3, 2'h1});
            @(negedge clk_in);
            sos = 1'b1;
            @(negedge clk_in);
            sos = 1'b0;
            chk({26'h0, lines}, 32'h0);
            nu = 0;
            for (j = 0; j < 64; j++) begin
                run_line(1'b0, u, d);
                if (u === 1'b1) nu++;
            end
            chk(32'(nu), lim_exp[k]);
            chk({26'h0, lines}, 32'h3f);
        end
        en = 1'b0; // loop off once the unlimited run has settled
        repeat (2) @(negedge clk_in);
        results();
    end
endmodule
